// ---- hw/mfpcpg_top.sv ----
// Pin configuration, power-good, settings boot/store and start-up control.
// Assumes an upstream bus engine handing over decoded commands, an NVM
// controller on this clock, and analog status pins from other domains.

// What this block does
// R1: Power-good flag set only when output in tolerance and no fault.
// R2: Power-good output resets active low, push-pull; both changeable by bus.
// R3: Config bit 5 selects push-pull or high impedance while active.
// R4: Config bits 7:6 select stand-alone 00 or droop share 10.
// R5: Config bit 2 enables the power-good output pin.
// R6: Config bit 0 enables pull on remote input, up when active low.
// R7: Reserved bit 1 reads 1 in droop share, 0 in stand-alone.
// R8: No tracking or external reference; those bits stay zero.
// R9: Config resets to 0x04 stand-alone or 0x86 droop-share variant.
// R10: Host uses high-impedance drive when power-good pins are paralleled.
// R11: Boot loads user set if present, else factory set.
// R12: User area ships empty, so first boot uses factory set.
// R13: Store-user copies working settings to storage for next power cycle.
// R14: Store-factory command is write protected.
// R15: Pre-bias start below target never sinks; it ramps up.
// R16: Above target it ramps down, sinking only for the limit time.
// R17: Switching frequency resets to 140 kHz, settable from 125 to 150.
// R18: Remote input disabled and floating by default; polarity from on/off config.
// R19: Unsupported modes or tracking/reference bits are refused and flagged invalid.
module mfpcpg_top #(
	parameter bit DROOP_VARIANT = 1'b0,
	parameter int TICK_CYCLES   = mfpcpg_pkg::TICK_CYCLES
) (
	input  wire logic        mclk_i,
	input  wire logic        sys_rst_i,
	input  wire logic        cmd_valid_i,
	input  wire logic        cmd_write_i,
	input  wire logic [7:0]  cmd_code_i,
	input  wire logic [15:0] cmd_wdata_i,
	output logic             rsp_valid_o,
	output logic             rsp_err_o,
	output logic [15:0]      rsp_rdata_o,
	input  wire logic        user_area_valid_i,
	output logic             load_req_o,
	output logic             load_user_o,
	input  wire logic        load_done_i,
	input  wire logic [7:0]  nvm_pin_cfg_i,
	input  wire logic [7:0]  nvm_onoff_i,
	input  wire logic [15:0] nvm_freq_i,
	input  wire logic [15:0] nvm_sink_i,
	input  wire logic        nvm_pg_pol_i,
	output logic             store_req_o,
	input  wire logic        store_done_i,
	input  wire logic        vout_in_tol_i,
	input  wire logic        fault_i,
	input  wire logic        out_enable_i,
	input  wire logic        prebias_above_i,
	input  wire logic        ramp_done_i,
	input  wire logic        sec_remote_i,
	output logic [7:0]       pin_cfg_o,
	output logic [7:0]       onoff_cfg_o,
	output logic [15:0]      freq_khz_o,
	output logic [15:0]      sink_limit_o,
	output logic             pg_pol_o,
	output logic             pg_o,
	output logic             pg_oe_o,
	output logic             remote_pull_en_o,
	output logic             remote_pull_up_o,
	output logic             remote_run_o,
	output logic             ramp_up_o,
	output logic             ramp_down_o,
	output logic             sink_en_o
);
	localparam int         TW      = $clog2(TICK_CYCLES + 1);
	localparam logic [7:0] PIN_RST = DROOP_VARIANT ? mfpcpg_pkg::PIN_RST_DROOP
		: mfpcpg_pkg::PIN_RST_STANDALONE;

	mfpcpg_pkg::mfpcpg_boot_t boot_st;
	logic [5:0]               s1, s2, s3, filt;
	logic [TW-1:0]            tick_cnt;
	logic                     tick;
	logic                     pg_flag;
	logic                     invalid, sink_tout, boot_user;
	logic                     wr, rd, pin_bad, freq_bad, clr;
	logic [7:0]               wd8;
	logic [15:0]              next_rdata;
	logic                     next_err;
	mfpcpg_seq_if             sq ();

	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (sys_rst_i);

	////////////////////////////////////////////////////////////////////////////
	// Pin synchronisers: accept a change only once stages two and three agree
	always_ff @(posedge mclk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			s1   <= 6'h00;
			s2   <= 6'h00;
			s3   <= 6'h00;
			filt <= 6'h00;
		end else begin
			s1   <= {sec_remote_i, ramp_done_i, prebias_above_i, out_enable_i,
				fault_i, vout_in_tol_i};
			s2   <= s1;
			s3   <= s2;
			filt <= (s2 & s3) | (filt & (s2 ^ s3));
		end
	end

	// One millisecond tick for the sink timer
	always_ff @(posedge mclk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			tick_cnt <= '0;
			tick     <= 1'b0;
		end else begin
			tick     <= (tick_cnt == TW'(TICK_CYCLES - 1));
			tick_cnt <= (tick_cnt == TW'(TICK_CYCLES - 1)) ? '0 : tick_cnt + TW'(1);
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Command decode; everything is refused until the boot load completes
	assign wd8      = cmd_wdata_i[7:0];
	assign wr       = cmd_valid_i && cmd_write_i && boot_st == mfpcpg_pkg::B_RUN;
	assign rd       = cmd_valid_i && !cmd_write_i && boot_st == mfpcpg_pkg::B_RUN;
	// R19 bad mode or unsupported bits
	assign pin_bad  = wd8[mfpcpg_pkg::PIN_MODE_LO] || wd8[mfpcpg_pkg::PIN_TRACK]
		|| wd8[mfpcpg_pkg::PIN_EXTREF];
	assign freq_bad = cmd_wdata_i < mfpcpg_pkg::FREQ_MIN || cmd_wdata_i > mfpcpg_pkg::FREQ_MAX;
	assign clr      = wr && cmd_code_i == mfpcpg_pkg::CMD_CLEAR_FAULTS;

	// Boot load, then store on request
	always_ff @(posedge mclk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			boot_st     <= mfpcpg_pkg::B_RESET;
			load_req_o  <= 1'b0;
			load_user_o <= 1'b0;
			store_req_o <= 1'b0;
			boot_user   <= 1'b0;
		end else begin
			case (boot_st)
				mfpcpg_pkg::B_RESET: begin
					// R11 R12 empty user area falls back to factory
					boot_st     <= mfpcpg_pkg::B_LOAD;
					load_req_o  <= 1'b1;
					load_user_o <= user_area_valid_i;
					boot_user   <= user_area_valid_i;
				end
				mfpcpg_pkg::B_LOAD: begin
					if (load_done_i) begin
						boot_st    <= mfpcpg_pkg::B_RUN;
						load_req_o <= 1'b0;
					end
				end
				mfpcpg_pkg::B_RUN: begin
					// R13 store working set
					if (wr && cmd_code_i == mfpcpg_pkg::CMD_STORE_USER) begin
						boot_st     <= mfpcpg_pkg::B_STORE;
						store_req_o <= 1'b1;
					end
				end
				mfpcpg_pkg::B_STORE: begin
					if (store_done_i) begin
						boot_st     <= mfpcpg_pkg::B_RUN;
						store_req_o <= 1'b0;
					end
				end
				default: boot_st <= mfpcpg_pkg::B_RESET;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Pin configuration register; reserved bit follows the mode
	always_ff @(posedge mclk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			// R9 variant reset value
			pin_cfg_o <= PIN_RST;
		end else if (boot_st == mfpcpg_pkg::B_LOAD && load_done_i) begin
			// R8 a corrupt stored byte cannot enable unsupported functions
			pin_cfg_o <= {nvm_pin_cfg_i[7], 1'b0, nvm_pin_cfg_i[5], 2'b00,
				nvm_pin_cfg_i[2], nvm_pin_cfg_i[7], nvm_pin_cfg_i[0]};
		end else if (wr && cmd_code_i == mfpcpg_pkg::CMD_PIN_CONFIG && !pin_bad) begin
			// R4 R7 mode and reserved bit
			pin_cfg_o <= {wd8[7:2], wd8[mfpcpg_pkg::PIN_MODE_HI], wd8[0]};
		end
	end

	// Other working settings
	always_ff @(posedge mclk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			// R2 R17 R18 defaults
			onoff_cfg_o  <= mfpcpg_pkg::ONOFF_RST;
			freq_khz_o   <= mfpcpg_pkg::FREQ_RST;
			sink_limit_o <= mfpcpg_pkg::SINK_LIMIT_RST;
			pg_pol_o     <= mfpcpg_pkg::PG_POL_RST;
		end else if (boot_st == mfpcpg_pkg::B_LOAD && load_done_i) begin
			onoff_cfg_o  <= nvm_onoff_i;
			freq_khz_o   <= (nvm_freq_i < mfpcpg_pkg::FREQ_MIN || nvm_freq_i > mfpcpg_pkg::FREQ_MAX)
				? mfpcpg_pkg::FREQ_RST : nvm_freq_i;
			sink_limit_o <= nvm_sink_i;
			pg_pol_o     <= nvm_pg_pol_i;
		end else if (wr) begin
			if (cmd_code_i == mfpcpg_pkg::CMD_ON_OFF_CONFIG) onoff_cfg_o <= wd8;
			// R17 range checked
			if (cmd_code_i == mfpcpg_pkg::CMD_FREQ && !freq_bad) freq_khz_o <= cmd_wdata_i;
			if (cmd_code_i == mfpcpg_pkg::CMD_SINK_LIMIT) sink_limit_o <= cmd_wdata_i;
			if (cmd_code_i == mfpcpg_pkg::CMD_PG_POLARITY) pg_pol_o <= cmd_wdata_i[0];
		end
	end

	// Sticky status; a new event in the clearing cycle wins
	always_ff @(posedge mclk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			invalid   <= 1'b0;
			sink_tout <= 1'b0;
		end else begin
			// R19 R14 refused data
			invalid   <= (wr && ((cmd_code_i == mfpcpg_pkg::CMD_PIN_CONFIG && pin_bad)
				|| (cmd_code_i == mfpcpg_pkg::CMD_FREQ && freq_bad)
				|| cmd_code_i == mfpcpg_pkg::CMD_STORE_DEFAULT)) || (invalid && !clr);
			sink_tout <= sq.timeout || (sink_tout && !clr);
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Read data and refusal
	always_comb begin
		next_rdata = 16'h0000;
		next_err   = 1'b0;
		case (cmd_code_i)
			mfpcpg_pkg::CMD_PIN_CONFIG:    next_rdata = {8'h00, pin_cfg_o};
			mfpcpg_pkg::CMD_ON_OFF_CONFIG: next_rdata = {8'h00, onoff_cfg_o};
			mfpcpg_pkg::CMD_FREQ:         next_rdata = freq_khz_o;
			mfpcpg_pkg::CMD_SINK_LIMIT:    next_rdata = sink_limit_o;
			mfpcpg_pkg::CMD_PG_POLARITY:   next_rdata = {15'h0000, pg_pol_o};
			mfpcpg_pkg::CMD_STATUS_WORD: begin
				next_rdata[mfpcpg_pkg::ST_INVALID]   = invalid;
				next_rdata[mfpcpg_pkg::ST_PG]        = pg_flag;
				next_rdata[mfpcpg_pkg::ST_SINK_TOUT] = sink_tout;
				next_rdata[mfpcpg_pkg::ST_STORING]   = store_req_o;
				next_rdata[mfpcpg_pkg::ST_BOOT_USER] = boot_user;
				next_err = cmd_write_i;
			end
			mfpcpg_pkg::CMD_CLEAR_FAULTS, mfpcpg_pkg::CMD_STORE_USER:
				next_err = !cmd_write_i;
			// R14 never copies into the factory area
			mfpcpg_pkg::CMD_STORE_DEFAULT: next_err = 1'b1;
			default: next_err = 1'b1;
		endcase
		if (boot_st != mfpcpg_pkg::B_RUN) next_err = 1'b1;
		if (cmd_write_i) begin
			next_rdata = 16'h0000;
			if (cmd_code_i == mfpcpg_pkg::CMD_PIN_CONFIG && pin_bad) next_err = 1'b1;
			if (cmd_code_i == mfpcpg_pkg::CMD_FREQ && freq_bad) next_err = 1'b1;
		end
	end

	always_ff @(posedge mclk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			rsp_valid_o <= 1'b0;
			rsp_err_o   <= 1'b0;
			rsp_rdata_o <= 16'h0000;
		end else begin
			rsp_valid_o <= cmd_valid_i;
			rsp_err_o   <= cmd_valid_i && next_err;
			rsp_rdata_o <= (rd && !next_err) ? next_rdata : 16'h0000;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Power-good flag and pin; active level comes from the polarity setting
	always_ff @(posedge mclk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			pg_flag <= 1'b0;
			pg_o    <= 1'b1;
			pg_oe_o <= 1'b0;
		end else begin
			// R1 tolerance and no fault
			pg_flag <= filt[0] && !filt[1];
			// R2 polarity
			pg_o    <= pg_flag ? pg_pol_o : !pg_pol_o;
			// R3 R5 drive mode and enable
			pg_oe_o <= pin_cfg_o[mfpcpg_pkg::PIN_PG_EN]
				&& !(pin_cfg_o[mfpcpg_pkg::PIN_PG_HIZ] && pg_flag);
		end
	end

	// Secondary remote input pull and run request
	always_ff @(posedge mclk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			remote_pull_en_o <= 1'b0;
			remote_pull_up_o <= 1'b0;
			remote_run_o     <= 1'b1;
		end else begin
			// R6 pull opposite the active level
			remote_pull_en_o <= pin_cfg_o[mfpcpg_pkg::PIN_PULL_EN];
			remote_pull_up_o <= !onoff_cfg_o[mfpcpg_pkg::ONOFF_POL];
			// R18 ignored while disabled
			remote_run_o     <= !onoff_cfg_o[mfpcpg_pkg::ONOFF_CTRL_EN]
				|| (filt[5] == onoff_cfg_o[mfpcpg_pkg::ONOFF_POL]);
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Start-up sequencer
	assign sq.start     = filt[2];
	assign sq.above     = filt[3];
	assign sq.ramp_done = filt[4];
	assign sq.tick      = tick;
	assign sq.limit     = sink_limit_o;
	assign ramp_up_o    = sq.ramp_up;
	assign ramp_down_o  = sq.ramp_down;
	assign sink_en_o    = sq.sink_en;

	mfpcpg_prebias u_prebias (
		.mclk_i    (mclk_i),
		.sys_rst_i (sys_rst_i),
		.sq        (sq.seq)
	);

	////////////////////////////////////////////////////////////////////////////
	sequence s_bad_pin_wr;
		wr && cmd_code_i == mfpcpg_pkg::CMD_PIN_CONFIG && pin_bad;
	endsequence

	pg_flag_a: assert property (pg_flag |-> $past(filt[0]) && !$past(filt[1])) // R1
		else $error("power-good flag without tolerance or with fault");
	pg_hiz_a: assert property (pin_cfg_o[5] && pin_cfg_o[2] && pg_flag // R3
		&& $stable(pin_cfg_o) |=> !pg_oe_o)
		else $error("power-good pin driven while active in high-z mode");
	pg_en_a: assert property (!pin_cfg_o[2] && $stable(pin_cfg_o) |=> !pg_oe_o) // R5
		else $error("power-good pin driven while disabled");
	bad_mode_a: assert property (s_bad_pin_wr |=> $stable(pin_cfg_o) && invalid // R19
		&& rsp_err_o)
		else $error("unsupported pin configuration accepted");
	track_zero_a: assert property (pin_cfg_o[4:3] == 2'b00 // R8
		&& pin_cfg_o[6] == 1'b0)
		else $error("unsupported pin configuration bits set");
	rsvd_bit_a: assert property (pin_cfg_o[1] == pin_cfg_o[7]) // R7
		else $error("reserved bit does not follow mode");
	freq_range_a: assert property (freq_khz_o >= 16'h007D && freq_khz_o <= 16'h0096) // R17
		else $error("switching frequency out of range");
	boot_sel_a: assert property ($rose(load_req_o) |-> load_user_o == $past(user_area_valid_i) // R11
		&& boot_st == mfpcpg_pkg::B_LOAD)
		else $error("boot set selection wrong");
	store_prot_a: assert property (wr && cmd_code_i == mfpcpg_pkg::CMD_STORE_DEFAULT // R14
		&& !store_req_o |=> rsp_err_o && !store_req_o ##1 !store_req_o)
		else $error("factory store not refused");
	pull_dir_a: assert property ($stable(onoff_cfg_o) // R6
		|=> remote_pull_up_o == !$past(onoff_cfg_o[1]))
		else $error("remote pull direction wrong");

endmodule : mfpcpg_top

// ---- hw/mfpcpg_pkg.sv ----
// Constants for the pin configuration and power-good block.
// Assumes a 20 MHz controller clock; command codes are the bus command bytes.
package mfpcpg_pkg;

	////////////////////////////////////////////////////////////////////////////
	// Command codes
	localparam logic [7:0] CMD_ON_OFF_CONFIG = 8'h02;
	localparam logic [7:0] CMD_CLEAR_FAULTS  = 8'h03;
	localparam logic [7:0] CMD_STORE_DEFAULT = 8'h11;
	localparam logic [7:0] CMD_STORE_USER    = 8'h15;
	localparam logic [7:0] CMD_FREQ         = 8'h33;
	localparam logic [7:0] CMD_SINK_LIMIT    = 8'h66;
	localparam logic [7:0] CMD_STATUS_WORD   = 8'h79;
	localparam logic [7:0] CMD_PG_POLARITY   = 8'hD0;
	localparam logic [7:0] CMD_PIN_CONFIG    = 8'hF9;

	////////////////////////////////////////////////////////////////////////////
	// Pin configuration fields
	localparam int PIN_MODE_HI = 7;
	localparam int PIN_MODE_LO = 6;
	localparam int PIN_PG_HIZ  = 5;
	localparam int PIN_TRACK   = 4;
	localparam int PIN_EXTREF  = 3;
	localparam int PIN_PG_EN   = 2;
	localparam int PIN_RSVD    = 1;
	localparam int PIN_PULL_EN = 0;
	localparam logic [7:0] PIN_RST_STANDALONE = 8'h04;
	localparam logic [7:0] PIN_RST_DROOP      = 8'h86;

	// On/off configuration fields; polarity 1 means active high
	localparam int ONOFF_CTRL_EN = 2;
	localparam int ONOFF_POL     = 1;
	localparam logic [7:0] ONOFF_RST = 8'h00;

	// Power-good polarity; 0 means active low
	localparam logic PG_POL_RST = 1'b0;

	// Switching frequency in kHz
	localparam logic [15:0] FREQ_RST = 16'h008C;
	localparam logic [15:0] FREQ_MIN = 16'h007D;
	localparam logic [15:0] FREQ_MAX = 16'h0096;

	// Sink time limit in milliseconds
	localparam logic [15:0] SINK_LIMIT_RST = 16'h0005;

	// Status word bits
	localparam int ST_INVALID   = 0;
	localparam int ST_PG        = 1;
	localparam int ST_SINK_TOUT = 2;
	localparam int ST_STORING   = 3;
	localparam int ST_BOOT_USER = 4;

	////////////////////////////////////////////////////////////////////////////
	// Timing: one millisecond tick
	localparam int CLK_NS      = 50;
	localparam int TICK_NS     = 1000000;
	localparam int TICK_CYCLES = TICK_NS / CLK_NS;

	////////////////////////////////////////////////////////////////////////////
	// State machines
	typedef enum logic [3:0] {
		B_RESET = 4'b0001,
		B_LOAD  = 4'b0010,
		B_RUN   = 4'b0100,
		B_STORE = 4'b1000
	} mfpcpg_boot_t;

	typedef enum logic [3:0] {
		P_IDLE = 4'b0001,
		P_UP   = 4'b0010,
		P_DOWN = 4'b0100,
		P_DONE = 4'b1000
	} mfpcpg_seq_t;

endpackage : mfpcpg_pkg

// ---- hw/mfpcpg_seq_if.sv ----
// Signals between the configuration block and its start-up sequencer.
// Assumes both ends run on the same controller clock.
interface mfpcpg_seq_if;
	logic        start;
	logic        above;
	logic        ramp_done;
	logic        tick;
	logic [15:0] limit;
	logic        ramp_up;
	logic        ramp_down;
	logic        sink_en;
	logic        timeout;

	modport ctl (output start, above, ramp_done, tick, limit,
		input ramp_up, ramp_down, sink_en, timeout);
	modport seq (input start, above, ramp_done, tick, limit,
		output ramp_up, ramp_down, sink_en, timeout);
endinterface : mfpcpg_seq_if

// ---- hw/mfpcpg_prebias.sv ----
// Pre-bias start-up sequencer: picks ramp direction and bounds sinking.
// Assumes start, above and ramp_done are already synchronised; tick is 1 ms.
module mfpcpg_prebias (
	input  wire logic mclk_i,
	input  wire logic sys_rst_i,
	mfpcpg_seq_if.seq sq
);
	mfpcpg_pkg::mfpcpg_seq_t st;
	logic [15:0]             sink_ms;
	logic                    start_q;

	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (sys_rst_i);

	////////////////////////////////////////////////////////////////////////////
	// Start edge detect
	always_ff @(posedge mclk_i or posedge sys_rst_i) begin
		if (sys_rst_i) start_q <= 1'b0;
		else start_q <= sq.start;
	end

	// R15 R16 direction and sink control
	always_ff @(posedge mclk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			st           <= mfpcpg_pkg::P_IDLE;
			sq.ramp_up   <= 1'b0;
			sq.ramp_down <= 1'b0;
			sq.sink_en   <= 1'b0;
			sq.timeout   <= 1'b0;
			sink_ms      <= 16'h0000;
		end else begin
			sq.timeout <= 1'b0;
			case (st)
				mfpcpg_pkg::P_IDLE: begin
					sink_ms <= 16'h0000;
					if (sq.start && !start_q) begin
						// Below target: ramp up, never sink
						st           <= sq.above ? mfpcpg_pkg::P_DOWN : mfpcpg_pkg::P_UP;
						sq.ramp_up   <= !sq.above;
						sq.ramp_down <= sq.above;
						sq.sink_en   <= sq.above && (sq.limit != 16'h0000);
					end
				end
				mfpcpg_pkg::P_UP: begin
					if (!sq.start || sq.ramp_done) begin
						st         <= sq.start ? mfpcpg_pkg::P_DONE : mfpcpg_pkg::P_IDLE;
						sq.ramp_up <= 1'b0;
						sq.sink_en <= sq.start;
					end
				end
				mfpcpg_pkg::P_DOWN: begin
					// Tick phase is free, so the sink window is limit-1 to limit ms
					if (sq.sink_en && sq.tick) begin
						sink_ms <= sink_ms + 16'h0001;
						if (sink_ms + 16'h0001 >= sq.limit) begin
							sq.sink_en <= 1'b0;
							sq.timeout <= 1'b1;
						end
					end
					if (!sq.start || sq.ramp_done) begin
						st           <= sq.start ? mfpcpg_pkg::P_DONE : mfpcpg_pkg::P_IDLE;
						sq.ramp_down <= 1'b0;
						sq.sink_en   <= sq.start;
					end
				end
				mfpcpg_pkg::P_DONE: begin
					// Normal regulation after the start-up ramp
					if (!sq.start) begin
						st         <= mfpcpg_pkg::P_IDLE;
						sq.sink_en <= 1'b0;
					end
				end
				default: begin
					st           <= mfpcpg_pkg::P_IDLE;
					sq.ramp_up   <= 1'b0;
					sq.ramp_down <= 1'b0;
					sq.sink_en   <= 1'b0;
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////
	sequence s_start_low;
		!start_q && sq.start && !sq.above && st == mfpcpg_pkg::P_IDLE;
	endsequence
	sequence s_start_high;
		!start_q && sq.start && sq.above && st == mfpcpg_pkg::P_IDLE;
	endsequence

	up_no_sink_a: assert property (s_start_low |=> sq.ramp_up && !sq.sink_en) // R15
		else $error("sink enabled while ramping up from pre-bias");
	down_dir_a: assert property (s_start_high |=> sq.ramp_down && !sq.ramp_up) // R16
		else $error("no ramp down above target");
	sink_stop_a: assert property (st == mfpcpg_pkg::P_DOWN && sq.sink_en && sq.tick // R16
		&& sink_ms + 16'h0001 >= sq.limit && sq.start && !sq.ramp_done
		|=> !sq.sink_en ##1 !sq.sink_en)
		else $error("sinking past the time limit");

endmodule : mfpcpg_prebias

// ---- bench/mfpcpg_nvm_model.sv ----
// NVM partner: answers boot loads and user-set stores of the block.
// Assumes the block's load/store level handshake on the same clock.
module mfpcpg_nvm_model (
	input  wire logic        mclk_i,
	input  wire logic        load_req_i,
	input  wire logic        store_req_i,
	input  wire logic [7:0]  pin_cfg_i,
	input  wire logic [15:0] freq_i,
	output logic             user_valid_o,
	output logic             load_done_o,
	output logic             store_done_o,
	output logic [7:0]       pin_cfg_o,
	output logic [15:0]      freq_o
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [7:0]  user_pin;
	logic [15:0] user_freq;
	logic [3:0]  wait_cnt;
	logic [7:0]  pin_now;
	logic [15:0] freq_now;
	////////////////////////////////////////////////////////////////////////////
	// user area empty
	initial begin
		user_valid_o = 1'b0;
		load_done_o = 1'b0;
		store_done_o = 1'b0;
		wait_cnt = 4'h0;
	end
	assign pin_now = user_valid_o ? user_pin : mfpcpg_pkg::PIN_RST_STANDALONE;
	assign freq_now = user_valid_o ? user_freq : mfpcpg_pkg::FREQ_RST;
	// Data only valid with the done pulse; inverted otherwise
	assign pin_cfg_o = load_done_o ? pin_now : ~pin_now;
	assign freq_o = load_done_o ? freq_now : ~freq_now;
	always @(posedge mclk_i) begin
		load_done_o <= 1'b0;
		store_done_o <= 1'b0;
		if ((load_req_i || store_req_i) && !load_done_o && !store_done_o) begin
			wait_cnt <= wait_cnt + 4'h1;
		end else begin
			wait_cnt <= 4'h0;
		end
		if (wait_cnt == 4'h6 && load_req_i) begin
			load_done_o <= 1'b1;
		end
		if (wait_cnt == 4'h6 && store_req_i) begin
			store_done_o <= 1'b1;
			user_pin <= pin_cfg_i;
			user_freq <= freq_i;
			user_valid_o <= 1'b1;
		end
	end
endmodule : mfpcpg_nvm_model

// ---- bench/test_multi_pin_config_and_power_good.sv ----
// Self-checking bench for the pin configuration and power-good block.
// Assumes the NVM partner model and a 10-cycle tick for short sink windows.
module test_multi_pin_config_and_power_good;
	timeunit 1ns;
	timeprecision 1ns;
	logic mclk_i = 1'b0, rst = 1'b1, cv = 1'b0, cw = 1'b0;
	logic [7:0] cc = 8'h00;
	logic [15:0] cd = 16'h0000;
	logic vtol = 1'b0, flt = 1'b0, oen = 1'b0, above = 1'b0, rdone = 1'b0, sec = 1'b0;
	logic rv, re, lreq, luser, ldone, sreq, sdone, uval, pol, pg, pg_oe;
	logic pull_en, pull_up, run, rup, rdn, sink;
	logic [7:0] pin, onoff, npin;
	logic [15:0] rdata, rd, freq, slim, nfreq;
	int fail_count = 0;
	int n_tests = 0;
	////////////////////////////////////////////////////////////////////////////
	mfpcpg_top #(.DROOP_VARIANT(1'b0), .TICK_CYCLES(10)) i_dut (
		.mclk_i(mclk_i), .sys_rst_i(rst), .cmd_valid_i(cv), .cmd_write_i(cw),
		.cmd_code_i(cc), .cmd_wdata_i(cd), .rsp_valid_o(rv), .rsp_err_o(re),
		.rsp_rdata_o(rdata), .user_area_valid_i(uval), .load_req_o(lreq),
		.load_user_o(luser), .load_done_i(ldone), .nvm_pin_cfg_i(npin),
		.nvm_onoff_i(mfpcpg_pkg::ONOFF_RST), .nvm_freq_i(nfreq),
		.nvm_sink_i(mfpcpg_pkg::SINK_LIMIT_RST), .nvm_pg_pol_i(mfpcpg_pkg::PG_POL_RST),
		.store_req_o(sreq), .store_done_i(sdone), .vout_in_tol_i(vtol), .fault_i(flt),
		.out_enable_i(oen), .prebias_above_i(above), .ramp_done_i(rdone),
		.sec_remote_i(sec), .pin_cfg_o(pin), .onoff_cfg_o(onoff), .freq_khz_o(freq),
		.sink_limit_o(slim), .pg_pol_o(pol), .pg_o(pg), .pg_oe_o(pg_oe),
		.remote_pull_en_o(pull_en), .remote_pull_up_o(pull_up), .remote_run_o(run),
		.ramp_up_o(rup), .ramp_down_o(rdn), .sink_en_o(sink));
	mfpcpg_nvm_model i_nvm (.mclk_i(mclk_i), .load_req_i(lreq), .store_req_i(sreq),
		.pin_cfg_i(pin), .freq_i(freq), .user_valid_o(uval), .load_done_o(ldone),
		.store_done_o(sdone), .pin_cfg_o(npin), .freq_o(nfreq));
	// Clock at 20 MHz
	always #25 mclk_i = ~mclk_i;
	////////////////////////////////////////////////////////////////////////////
	task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
		n_tests++;
		if (g !== e) begin
			$display("BAD %s expected %h seen %h", nm, e, g);
			fail_count++;
		end
	endtask : chk
	task automatic cyc(input int n);
		repeat (n) @(negedge mclk_i);
	endtask : cyc
	// One command; answer sampled in the cycle in which it stands
	task automatic cmd(input logic w, input logic [7:0] c, input logic [15:0] d, input logic e);
		cv = 1'b1;
		cw = w;
		cc = c;
		cd = d;
		cyc(1);
		chk("rsp_valid", 1'b1, rv);
		chk("rsp_err", e, re);
		rd = rdata;
		cv = 1'b0;
		cyc(1);
	endtask : cmd
	task automatic boot;
		rst = 1'b1;
		cyc(10);
		rst = 1'b0;
		cyc(2);
		for (int i = 0; i < 40 && lreq !== 1'b0; i++) cyc(1);
		chk("load_req", 1'b0, lreq);
		cyc(3);
	endtask : boot
	task automatic t_defaults;
		chk("load_user", 1'b0, luser);
		chk("pin_cfg", mfpcpg_pkg::PIN_RST_STANDALONE, pin);
		chk("freq", mfpcpg_pkg::FREQ_RST, freq);
		chk("pg_pol", 1'b0, pol);
		chk("pg_oe", 1'b1, pg_oe);
		chk("pg", 1'b1, pg);
		chk("pull_en", 1'b0, pull_en);
		chk("run", 1'b1, run);
	endtask : t_defaults
	task automatic t_pincfg;
		logic [7:0] ok [12] = '{8'h82, 8'h83, 8'h86, 8'h87, 8'hA6, 8'hA7,
			8'h00, 8'h01, 8'h04, 8'h05, 8'h24, 8'h25};
		logic [7:0] bad [4] = '{8'h44, 8'hC4, 8'h14, 8'h0C};
		foreach (ok[i]) begin
			cmd(1'b1, mfpcpg_pkg::CMD_PIN_CONFIG, {8'h00, ok[i]}, 1'b0);
			chk("pin_cfg", ok[i], pin);
			cyc(1);
			chk("pull_en", ok[i][0], pull_en);
			if (ok[i][0]) chk("pull_up", 1'b1, pull_up);
			chk("pg_oe", ok[i][2], pg_oe);
		end
		foreach (bad[i]) begin
			cmd(1'b1, mfpcpg_pkg::CMD_PIN_CONFIG, {8'h00, bad[i]}, 1'b1);
			chk("pin_cfg", 8'h25, pin);
			cmd(1'b0, mfpcpg_pkg::CMD_STATUS_WORD, 16'h0000, 1'b0);
			chk("invalid", 1'b1, rd[mfpcpg_pkg::ST_INVALID]);
			cmd(1'b1, mfpcpg_pkg::CMD_CLEAR_FAULTS, 16'h0000, 1'b0);
		end
	endtask : t_pincfg
	task automatic t_pg;
		cmd(1'b1, mfpcpg_pkg::CMD_PIN_CONFIG, 16'h0004, 1'b0);
		vtol = 1'b1;
		cyc(8);
		chk("pg", 1'b0, pg);
		cmd(1'b0, mfpcpg_pkg::CMD_STATUS_WORD, 16'h0000, 1'b0);
		chk("status_pg", 1'b1, rd[mfpcpg_pkg::ST_PG]);
		flt = 1'b1;
		cyc(8);
		chk("pg", 1'b1, pg);
		flt = 1'b0;
		cmd(1'b1, mfpcpg_pkg::CMD_PG_POLARITY, 16'h0001, 1'b0);
		cyc(8);
		chk("pg", 1'b1, pg);
		cmd(1'b1, mfpcpg_pkg::CMD_PIN_CONFIG, 16'h0024, 1'b0);
		cyc(2);
		chk("pg_oe", 1'b0, pg_oe);
		vtol = 1'b0;
		cyc(8);
		chk("pg_oe", 1'b1, pg_oe);
		cmd(1'b1, mfpcpg_pkg::CMD_ON_OFF_CONFIG, 16'h0006, 1'b0);
		chk("onoff", 8'h06, onoff);
		chk("run", 1'b0, run);
		sec = 1'b1;
		cyc(6);
		chk("run", 1'b1, run);
	endtask : t_pg
	task automatic t_freq;
		logic [15:0] f [4] = '{16'h007D, 16'h0096, 16'h007C, 16'h0097};
		foreach (f[i]) begin
			cmd(1'b1, mfpcpg_pkg::CMD_FREQ, f[i], i > 1);
			chk("freq", (i > 1) ? 16'h0096 : f[i], freq);
		end
	endtask : t_freq
	task automatic t_store;
		cmd(1'b1, mfpcpg_pkg::CMD_STORE_DEFAULT, 16'h0000, 1'b1);
		cmd(1'b1, mfpcpg_pkg::CMD_PIN_CONFIG, 16'h0025, 1'b0);
		cmd(1'b1, mfpcpg_pkg::CMD_FREQ, 16'h007D, 1'b0);
		cmd(1'b1, mfpcpg_pkg::CMD_STORE_USER, 16'h0000, 1'b0);
		chk("store_req", 1'b1, sreq);
		for (int i = 0; i < 40 && sreq !== 1'b0; i++) cyc(1);
		chk("store_req", 1'b0, sreq);
		boot();
		chk("load_user", 1'b1, luser);
		chk("pin_cfg", 8'h25, pin);
		chk("freq", 16'h007D, freq);
	endtask : t_store
	task automatic t_prebias;
		int n = 0;
		cmd(1'b1, mfpcpg_pkg::CMD_SINK_LIMIT, 16'h0002, 1'b0);
		above = 1'b1;
		oen = 1'b1;
		repeat (60) begin
			cyc(1);
			if (sink === 1'b1) n++;
		end
		chk("sink_window", 1'b1, n >= 10 && n <= 20);
		chk("ramp_down", 1'b1, rdn);
		cmd(1'b0, mfpcpg_pkg::CMD_STATUS_WORD, 16'h0000, 1'b0);
		chk("sink_tout", 1'b1, rd[mfpcpg_pkg::ST_SINK_TOUT]);
		rdone = 1'b1;
		cyc(8);
		chk("ramp_down", 1'b0, rdn);
		{oen, rdone, above} = 3'b000;
		cyc(8);
		oen = 1'b1;
		n = 0;
		repeat (30) begin
			cyc(1);
			if (sink !== 1'b0) n++;
		end
		chk("ramp_up", 1'b1, rup);
		chk("no_sink", 16'h0000, n);
		oen = 1'b0;
	endtask : t_prebias
	task automatic end_of_test;
		$display("checks %0d mismatches %0d", n_tests, fail_count);
		if (fail_count == 0 && n_tests > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask : end_of_test
	////////////////////////////////////////////////////////////////////////////
	// Main sequence
	initial begin
		boot();
		t_defaults();
		t_pincfg();
		t_pg();
		t_freq();
		t_store();
		t_prebias();
		end_of_test();
	end
	// Watchdog: run needs well under 3000 cycles
	initial begin
		#(8000 * 50);
		fail_count++;
		end_of_test();
	end
endmodule : test_multi_pin_config_and_power_good
